// ### shared/eau_pkg.sv
package eau_pkg;
  localparam int EAU_WORD_W  = 12;
  localparam int EAU_SC_W    = 5;
  localparam int EAU_CODE_W  = 3;
  // Memory word bit positions (bit 00 is the most significant bit)
  localparam int EAU_B00 = 11;
  localparam int EAU_B03 = 8;
  localparam int EAU_B04 = 7;
  localparam int EAU_B05 = 6;
  localparam int EAU_B06 = 5;
  localparam int EAU_B07 = 4;
  localparam int EAU_B08 = 3;
  localparam int EAU_B09 = 2;
  localparam int EAU_B10 = 1;
  localparam int EAU_B11 = 0;
  // Operation codes from bits 08..10 (code bit 0 = bit 08)
  localparam logic [2:0] EAU_CODE_NONE = 3'h0;
  localparam logic [2:0] EAU_CODE_SCL  = 3'h4;
  localparam logic [2:0] EAU_CODE_NMI  = 3'h5;
  localparam logic [2:0] EAU_CODE_MUY  = 3'h2;
  localparam logic [2:0] EAU_CODE_DVI  = 3'h6;
  localparam logic [2:0] EAU_CODE_SHL  = 3'h1;
  localparam logic [2:0] EAU_CODE_ASR  = 3'h3;
  localparam logic [2:0] EAU_CODE_LSR  = 3'h7;
  // Reset values
  localparam logic [11:0] EAU_MQ_RST   = 12'h000;
  localparam logic [4:0]  EAU_SC_RST   = 5'h00;
  localparam logic [2:0]  EAU_CODE_RST = 3'h0;
  // Timing
  localparam int EAU_CLK_NS     = 40;
  localparam int EAU_MIN_OP_NS  = 7800;
  localparam int EAU_MIN_OP_CYC = (EAU_MIN_OP_NS + EAU_CLK_NS - 1) / EAU_CLK_NS;
  localparam int EAU_STEP_CYC   = 1;
  typedef enum logic [1:0] {EAU_IDLE, EAU_WAIT_OPND, EAU_RUN, EAU_DONE} eau_state_t;
endpackage

// ### src/eau_decode.sv
`timescale 1ns/100ps
module eau_decode (
  // Memory word and processor timing
  input  wire logic [11:0] memory_buffer_word,
  input  wire logic        fetch_state,
  input  wire logic        operate_class,
  input  wire logic        operate_phase_two,
  input  wire logic        time_pulse_three,
  // Decoded strobes and gates
  output logic             unit_instr,
  output logic             arith_instr,
  output logic             ext_instr_strobe,
  output logic             acc_load_strobe,
  output logic             quotient_reg_load,
  output logic             acc_to_quotient_gate,
  output logic             acc_feedback_gate,
  output logic             quotient_to_acc_gate,
  output logic             count_to_acc_gate,
  output logic             opcode_capture
);
  import eau_pkg::*;
  logic [11:0] w;
  assign w = memory_buffer_word;
  assign unit_instr = &w[EAU_B00:EAU_B03] & w[EAU_B11];
  assign arith_instr = unit_instr & ~(|w[EAU_B04:EAU_B07])
                       & (|w[EAU_B08:EAU_B10]);
  assign ext_instr_strobe = fetch_state & operate_class & w[EAU_B03] & w[EAU_B11];
  // Foreign words with bits 03 and 11 set must not disturb unit registers
  assign opcode_capture = ext_instr_strobe & unit_instr & time_pulse_three;
  assign acc_load_strobe = time_pulse_three & fetch_state & operate_class
                           & unit_instr;
  assign quotient_reg_load = time_pulse_three & ext_instr_strobe & unit_instr
                             & w[EAU_B07];
  assign acc_to_quotient_gate = w[EAU_B11] & operate_phase_two & ~w[EAU_B04]
                                & w[EAU_B07];
  assign acc_feedback_gate = operate_phase_two & ~acc_to_quotient_gate
                             & ~w[EAU_B04];
  assign quotient_to_acc_gate = w[EAU_B05] & w[EAU_B11] & operate_phase_two;
  assign count_to_acc_gate = w[EAU_B06] & w[EAU_B11] & operate_phase_two;
endmodule

// ### src/eau_sequencer.sv
`timescale 1ns/100ps
module eau_sequencer #(
  parameter int MIN_OP_CYC = eau_pkg::EAU_MIN_OP_CYC
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Control
  input  wire logic                   start,
  input  wire logic                   need_operand,
  input  wire logic                   operand_ready,
  input  wire logic                   count_hit,
  // Status
  output logic                        running,
  output logic                        step,
  output logic                        hold_flag,
  output logic                        arith_done_flag
);
  import eau_pkg::*;
  typedef struct packed {
    eau_state_t  st;
    logic [12:0] cnt;
    logic        done;
  } eau_seq_t;
  eau_seq_t s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      EAU_IDLE: begin
        if (start) begin
          s_next.cnt = 13'h0000;
          s_next.st = need_operand ? EAU_WAIT_OPND : EAU_RUN;
        end
      end
      EAU_WAIT_OPND: begin
        if (operand_ready) begin
          s_next.st = EAU_RUN;
        end
      end
      EAU_RUN: begin
        if (s_reg.cnt != 13'h1fff) begin
          s_next.cnt = s_reg.cnt + 13'h0001;
        end
        // Never finish faster than the documented minimum
        if (count_hit && (int'(s_reg.cnt) >= MIN_OP_CYC - 1)) begin
          s_next.st = EAU_DONE;
        end
      end
      EAU_DONE: begin
        s_next.done = 1'b1;
        s_next.st = EAU_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '{st: EAU_IDLE, cnt: 13'h0000, done: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign running = (s_reg.st == EAU_RUN);
  assign step = running & ~count_hit;
  assign hold_flag = (s_reg.st != EAU_IDLE);
  assign arith_done_flag = s_reg.done;
endmodule

// ### src/eau_top.sv
`timescale 1ns/100ps
module eau_top #(
  parameter int MIN_OP_CYC = eau_pkg::EAU_MIN_OP_CYC
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Processor timing and state
  input  wire logic                        fetch_state,
  input  wire logic                        execute_state,
  input  wire logic                        operate_class,
  input  wire logic                        time_state_three,
  input  wire logic                        time_pulse_three,
  input  wire logic                        operate_phase_two,
  // Processor data
  input  wire logic [eau_pkg::EAU_WORD_W-1:0] memory_buffer_word,
  input  wire logic [eau_pkg::EAU_WORD_W-1:0] main_working_reg,
  // Accumulator write-back
  output logic                             acc_load_strobe,
  output logic [eau_pkg::EAU_WORD_W-1:0]   acc_next_value,
  // Pause control toward the processor
  output logic                             hold_flag,
  output logic                             arith_done_flag,
  output logic                             time_state_four_set,
  // Visible registers
  output logic [eau_pkg::EAU_WORD_W-1:0]   mult_quotient_reg,
  output logic [eau_pkg::EAU_SC_W-1:0]     step_count_reg,
  output logic [eau_pkg::EAU_CODE_W-1:0]   ext_opcode_reg
);
  import eau_pkg::*;

  // Six timing levels plus memory word and accumulator
  localparam int NSYNC = 6 + 24;

  typedef struct packed {
    logic [11:0]      mq;
    logic [4:0]       sc;
    logic [2:0]       code;
    logic [11:0]      mb;
    logic [11:0]      acc;
    logic             ald;
    logic [NSYNC-1:0] sy1;
    logic [NSYNC-1:0] sy2;
    logic             tp3d;
  } eau_state_s_t;
  eau_state_s_t r_reg, r_next;

  // Two-flop synchronisers on processor inputs; only the second stage is read
  logic [NSYNC-1:0] pins_raw;
  assign pins_raw = {fetch_state, execute_state, operate_class, time_state_three,
                     time_pulse_three, operate_phase_two, memory_buffer_word,
                     main_working_reg};
  logic        f_s, e_s, o_s, ts3_s, tp3_s, op2_s;
  logic [11:0] mb_s, ac_s;
  assign {f_s, e_s, o_s, ts3_s, tp3_s, op2_s, mb_s, ac_s} = r_reg.sy2;

  // Time pulse is acted on at its rising edge only
  logic tp3_edge;
  assign tp3_edge = tp3_s & ~r_reg.tp3d;

  logic unit_instr, arith_instr, ext_instr_strobe, acc_ld, q_load;
  logic a2q_gate, fb_gate, q2a_gate, sc2a_gate, opcode_capture;
  eau_decode u_dec (
    .memory_buffer_word   (mb_s),
    .fetch_state          (f_s),
    .operate_class        (o_s),
    .operate_phase_two    (op2_s),
    .time_pulse_three     (tp3_edge),
    .unit_instr           (unit_instr),
    .arith_instr          (arith_instr),
    .ext_instr_strobe     (ext_instr_strobe),
    .acc_load_strobe      (acc_ld),
    .quotient_reg_load    (q_load),
    .acc_to_quotient_gate (a2q_gate),
    .acc_feedback_gate    (fb_gate),
    .quotient_to_acc_gate (q2a_gate),
    .count_to_acc_gate    (sc2a_gate),
    .opcode_capture       (opcode_capture)
  );

  logic is_nmi, need_opnd, start, count_hit, step, seq_done;
  assign is_nmi = (mb_s[EAU_B08:EAU_B10] == {EAU_CODE_NMI[0], EAU_CODE_NMI[1],
                                               EAU_CODE_NMI[2]});
  // Load of the count alone needs no timing
  assign start = opcode_capture & arith_instr
                 & (mb_s[EAU_B08:EAU_B10] != 3'h1);
  assign need_opnd = ~is_nmi;
  assign count_hit = (r_reg.sc == 5'h1f);

  eau_sequencer #(.MIN_OP_CYC(MIN_OP_CYC)) u_seq (
    .clk             (clk),
    .rst             (rst),
    .start           (start),
    .need_operand    (need_opnd),
    .operand_ready   (e_s & tp3_edge),
    .count_hit       (count_hit),
    .running         (),
    .step            (step),
    .hold_flag       (hold_flag),
    .arith_done_flag (seq_done)
  );

  // Phase-two value toward the accumulator: feedback OR register sources
  logic [11:0] ac_phase1, ac_val;
  logic        clr_acc;
  always_comb begin
    // Bit 04 clears the accumulator before phase two
    clr_acc = mb_s[EAU_B04] & unit_instr & ts3_s;
    ac_phase1 = clr_acc ? 12'h000 : ac_s;
    ac_val = fb_gate ? ac_phase1 : 12'h000;
    if (q2a_gate) begin
      ac_val = ac_val | r_reg.mq;
    end
    if (sc2a_gate) begin
      ac_val = ac_val | {7'h00, r_reg.sc};
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.ald = 1'b0;
    if (opcode_capture) begin
      r_next.code = {mb_s[EAU_B10], mb_s[EAU_B09], mb_s[EAU_B08]};
    end
    if (q_load) begin
      // Cleared in phase one, then gated accumulator copy in phase two
      r_next.mq = a2q_gate ? ac_s : 12'h000;
    end
    if (acc_ld) begin
      r_next.acc = ac_val;
      r_next.ald = 1'b1;
    end
    if (opcode_capture && (|mb_s[EAU_B08:EAU_B10]) && !mb_s[EAU_B04] && !mb_s[EAU_B05]) begin
      // Shift ops and count load take the inverted count; others start at zero
      unique case ({mb_s[EAU_B10], mb_s[EAU_B09], mb_s[EAU_B08]})
        EAU_CODE_SCL, EAU_CODE_SHL, EAU_CODE_ASR, EAU_CODE_LSR:
          r_next.sc = ~mb_s[EAU_B07:EAU_B11];
        default:
          r_next.sc = EAU_SC_RST;
      endcase
    end else if (opcode_capture && arith_instr) begin
      r_next.sc = EAU_SC_RST;
    end
    if (e_s && tp3_edge && hold_flag) begin
      r_next.mb = mb_s;
      // Shift count operand replaces the loaded count
      if (r_reg.code == EAU_CODE_SHL || r_reg.code == EAU_CODE_ASR
          || r_reg.code == EAU_CODE_LSR) begin
        r_next.sc = ~mb_s[EAU_B07:EAU_B11];
      end
    end
    if (step) begin
      r_next.sc = r_reg.sc + 5'h01;
      unique case (r_reg.code)
        EAU_CODE_SHL, EAU_CODE_NMI:
          r_next.mq = {r_reg.mq[10:0], 1'b0};
        EAU_CODE_ASR:
          r_next.mq = {r_reg.mq[11], r_reg.mq[11:1]};
        EAU_CODE_LSR:
          r_next.mq = {1'b0, r_reg.mq[11:1]};
        default:
          r_next.mq = r_reg.mq; // Datapaths for multiply and divide lie outside
      endcase
    end
    r_next.sy1 = pins_raw;
    r_next.sy2 = r_reg.sy1;
    r_next.tp3d = tp3_s;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '{mq: EAU_MQ_RST, sc: EAU_SC_RST, code: EAU_CODE_RST, mb: 12'h000,
                 acc: 12'h000, ald: 1'b0, sy1: '0, sy2: '0, tp3d: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign acc_load_strobe = r_reg.ald;
  assign acc_next_value = r_reg.acc;
  // Done rises on the edge that drops the hold, so no gap without either
  assign arith_done_flag = seq_done;
  assign time_state_four_set = seq_done;
  assign mult_quotient_reg = r_reg.mq;
  assign step_count_reg = r_reg.sc;
  assign ext_opcode_reg = r_reg.code;
endmodule

// ### tb/eau_assertions.sv
`timescale 1ns/100ps
module eau_assertions #(
  parameter int MIN_OP_CYC = eau_pkg::EAU_MIN_OP_CYC
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Processor side
  input wire logic        fetch_state,
  input wire logic        operate_class,
  input wire logic        time_pulse_three,
  input wire logic [11:0] memory_buffer_word,
  input wire logic [11:0] main_working_reg,
  // Unit side
  input wire logic        acc_load_strobe,
  input wire logic [11:0] acc_next_value,
  input wire logic        hold_flag,
  input wire logic        arith_done_flag,
  input wire logic [11:0] mult_quotient_reg,
  input wire logic [2:0]  ext_opcode_reg
);
  import eau_pkg::*;
  wire  [11:0] w      = memory_buffer_word;
  wire         unit_w = &{w[11:8], w[0]};
  logic [8:0]  hold_cnt_reg;
  // Saturates so a stuck pause cannot wrap back under the minimum
  always_ff @(posedge clk) begin
    if (rst || !hold_flag) hold_cnt_reg <= 9'h000;
    else if (hold_cnt_reg != 9'h1ff) hold_cnt_reg <= hold_cnt_reg + 9'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_strobe_follows: assert property ($rose(time_pulse_three) && fetch_state
    && operate_class && unit_w |-> ##[3:5] acc_load_strobe) else $error("strobe missing");
  a_strobe_single: assert property (acc_load_strobe |=> !acc_load_strobe)
    else $error("strobe too long");
  a_strobe_unit: assert property (acc_load_strobe |-> $past(unit_w && fetch_state, 4))
    else $error("strobe without unit word");
  a_opcode_capture: assert property (acc_load_strobe |-> ext_opcode_reg ==
    {$past(w[1], 4), $past(w[2], 4), $past(w[3], 4)}) else $error("opcode wrong");
  a_opcode_holds: assert property (!acc_load_strobe |-> $stable(ext_opcode_reg))
    else $error("opcode moved");
  a_mq_cleared: assert property (acc_load_strobe && $past(w[7] && w[4], 4)
    |-> mult_quotient_reg == 12'h000) else $error("mq not cleared");
  a_mq_from_acc: assert property (acc_load_strobe && $past(!w[7] && w[4], 4)
    |-> mult_quotient_reg == $past(main_working_reg, 4)) else $error("mq not loaded");
  a_acc_cleared: assert property (acc_load_strobe && $past((w[7] || w[4]) &&
    w[6:5] == 2'h0, 4) |-> acc_next_value == 12'h000) else $error("acc not cleared");
  a_acc_or_mq: assert property (acc_load_strobe && $past(w[7:4] == 4'h4, 4)
    |-> acc_next_value == ($past(main_working_reg, 4) | mult_quotient_reg))
    else $error("acc or mq wrong");
  a_acc_kept: assert property (acc_load_strobe && $past(w[7:4] == 4'h0, 4)
    |-> acc_next_value == $past(main_working_reg, 4)) else $error("acc not kept");
  a_hold_starts: assert property (acc_load_strobe && $past(w[7:4] == 4'h0
    && w[3:2] != 2'h0, 4) |-> ##[0:1] hold_flag) else $error("no pause");
  a_done_ends_hold: assert property ($fell(hold_flag) |-> arith_done_flag)
    else $error("pause ended without done");
  a_hold_min_time: assert property ($fell(hold_flag) |-> hold_cnt_reg >= MIN_OP_CYC)
    else $error("pause too short");
endmodule

// ### tb/eau_host_model.sv
`timescale 1ns/100ps
module eau_host_model (
  // Clock
  input wire logic        clk,
  // From the unit
  input wire logic        acc_load_strobe,
  input wire logic [11:0] acc_next_value,
  input wire logic        hold_flag,
  input wire logic        time_state_four_set,
  // Processor timing and data
  output logic            fetch_state,
  output logic            execute_state,
  output logic            operate_class,
  output logic            time_state_three,
  output logic            time_pulse_three,
  output logic            operate_phase_two,
  output logic [11:0]     memory_buffer_word,
  output logic [11:0]     main_working_reg
);
  int   n_done = 0;
  logic held   = 1'b0;
  initial begin
    {fetch_state, execute_state, operate_class} = 3'h0;
    {time_state_three, time_pulse_three, operate_phase_two} = 3'h0;
    memory_buffer_word = 12'h000;
    main_working_reg = 12'h000;
  end
  always @(posedge clk) begin
    if (acc_load_strobe) main_working_reg <= acc_next_value;
    if (time_state_four_set) n_done <= n_done + 1;
  end
  // Each level held three cycles, longer than the unit's synchronisers need
  task automatic cycle(input logic [11:0] word, input logic f);
    @(posedge clk);
    memory_buffer_word <= word;
    {fetch_state, execute_state, operate_class} <= {f, !f, f};
    repeat (3) @(posedge clk);
    time_state_three <= 1'b1;
    operate_phase_two <= f;
    repeat (3) @(posedge clk);
    time_pulse_three <= 1'b1;
    repeat (3) @(posedge clk);
    {time_state_three, time_pulse_three, operate_phase_two} <= 3'h0;
    repeat (3) @(posedge clk);
    {fetch_state, execute_state, operate_class} <= 3'h0;
    memory_buffer_word <= ~word;
  endtask
  task automatic instr(input logic [11:0] word, ac, opnd);
    int i;
    @(posedge clk);
    main_working_reg <= ac;
    cycle(word, 1'b1);
    @(negedge clk);
    held = hold_flag;
    if (held && word[3:1] != 3'h5) cycle(opnd, 1'b0);
    // Processor stands still while paused
    for (i = 0; i < 600 && hold_flag; i++) @(negedge clk);
    // Let the done pulse reach the completion count before anyone looks
    repeat (2) @(negedge clk);
  endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
module tb;
  import eau_pkg::*;
  localparam int MIN_OP_CYC = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        fetch_state, execute_state, operate_class, time_state_three;
  logic        time_pulse_three, operate_phase_two, acc_load_strobe;
  logic        hold_flag, arith_done_flag, time_state_four_set;
  logic [11:0] memory_buffer_word, main_working_reg, acc_next_value, mult_quotient_reg;
  logic [4:0]  step_count_reg;
  logic [2:0]  ext_opcode_reg;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          exp_done = 0;
  int          k;
  always #20 clk = ~clk;
  eau_top #(.MIN_OP_CYC(MIN_OP_CYC)) dut_u (.clk, .rst, .fetch_state, .execute_state,
    .operate_class, .time_state_three, .time_pulse_three, .operate_phase_two,
    .memory_buffer_word, .main_working_reg, .acc_load_strobe, .acc_next_value, .hold_flag,
    .arith_done_flag, .time_state_four_set, .mult_quotient_reg, .step_count_reg,
    .ext_opcode_reg);
  eau_host_model host_u (.clk, .acc_load_strobe, .acc_next_value, .hold_flag,
    .time_state_four_set, .fetch_state, .execute_state, .operate_class, .time_state_three,
    .time_pulse_three, .operate_phase_two, .memory_buffer_word, .main_working_reg);
  task automatic chk(input string name, input logic [11:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic xfer(input logic [11:0] word, ac, acc, mq);
    host_u.instr(word, ac, 12'h003);
    chk("acc", acc, main_working_reg);
    chk("mq", mq, mult_quotient_reg);
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("mq", 12'h000, mult_quotient_reg);
    chk("sc", 12'h000, {7'h00, step_count_reg});
    chk("code", 12'h000, {9'h000, ext_opcode_reg});
    chk("pause", 12'h000, {10'h000, hold_flag, arith_done_flag});
    // Every code of bits 08-10; only code 0 and the count load leave the processor running
    for (k = 0; k < 8; k++) begin
      host_u.instr({8'hf0, k[0], k[1], k[2], 1'b1}, 12'h0a5, 12'h003);
      if (k != 0 && k != 4) exp_done++;
      chk("code", {9'h000, k[2:0]}, {9'h000, ext_opcode_reg});
      chk("held", (k != 0 && k != 4) ? 12'h001 : 12'h000, {11'h000, host_u.held});
      chk("done", exp_done[11:0], host_u.n_done[11:0]);
      chk("pause", 12'h000, {11'h000, hold_flag});
      chk("acc", 12'h0a5, main_working_reg);
    end
    xfer(12'hf11, 12'ha5c, 12'h000, 12'ha5c);
    xfer(12'hf41, 12'h003, 12'ha5f, 12'ha5c);
    xfer(12'hfc1, 12'h7ff, 12'ha5c, 12'ha5c);
    xfer(12'hf81, 12'hfff, 12'h000, 12'ha5c);
    xfer(12'hf90, 12'h555, 12'h555, 12'ha5c);
    xfer(12'h791, 12'h555, 12'h555, 12'ha5c);
    xfer(12'he91, 12'h555, 12'h555, 12'ha5c);
    xfer(12'hf03, 12'h0f0, 12'h0f0, 12'ha5c);
    chk("sc", 12'h01c, {7'h00, step_count_reg});
    xfer(12'hf21, 12'h100, 12'h11c, 12'ha5c);
    xfer(12'hfa1, 12'hfff, 12'h01c, 12'ha5c);
    xfer(12'hf91, 12'h123, 12'h000, 12'h000);
    print_verdict();
  end
  // Whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
bind eau_top eau_assertions #(.MIN_OP_CYC(MIN_OP_CYC)) chk_u (.clk, .rst, .fetch_state,
  .operate_class, .time_pulse_three, .memory_buffer_word, .main_working_reg,
  .acc_load_strobe, .acc_next_value, .hold_flag, .arith_done_flag, .mult_quotient_reg,
  .ext_opcode_reg);
